// *** verilog/nfp_defines.svh ***
`ifndef NFP_DEFINES_SVH
`define NFP_DEFINES_SVH

// pin widths
`define NFP_ADDR_W 25
`define NFP_DQ_W 16
`define NFP_TOP_BIT 24

// read configuration fields
`define NFP_CFG_W 16
`define NFP_CFG_WAIT_POL_BIT 10
`define NFP_CFG_ASYNC_BIT 15
`define NFP_CFG_RESET 16'h8400

// link clock edges of initial latency in a burst
`define NFP_LATENCY_EDGES 3'h3

// data path sizing
`define NFP_FIFO_DEPTH 4
`define NFP_MEM_LOW_BITS 4
`define NFP_MEM_AW 5
`define NFP_MEM_ERASED 16'hFFFF

`endif

// *** verilog/nfp_pkg.sv ***
`include "nfp_defines.svh"

package nfp_pkg;

	// pin levels as seen by the device
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic adv_n;
		logic link_clk;
		logic wide;
		logic [`NFP_ADDR_W-1:0] a;
		logic [`NFP_DQ_W-1:0] dq;
	} nfp_pins_s;

	typedef enum logic [1:0] {
		NFP_IDLE = 2'h0,
		NFP_FILL = 2'h1,
		NFP_BURST = 2'h3
	} nfp_burst_e;

	typedef struct packed {
		nfp_pins_s pin1;
		nfp_pins_s pin2;
		nfp_pins_s pin_prev;
		logic [`NFP_CFG_W-1:0] cfg;
		logic wide;
		logic strap_done;
		logic [`NFP_ADDR_W-1:0] addr;
		logic captured;
		nfp_burst_e burst;
		logic [2:0] lat_cnt;
		logic [`NFP_ADDR_W-1:0] fill_addr;
		logic rd_pend;
		logic wait_asrt;
		logic [`NFP_DQ_W-1:0] dq_o;
		logic dq_oe_n;
		logic wait_o;
		logic wait_oe_n;
		logic [1:0] die_act;
		logic standby;
	} nfp_state_s;

endpackage : nfp_pkg

// *** verilog/nfp_fifo.sv ***
`timescale 1ns/1ns

module nfp_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0] count;
	} nfp_fifo_s;

	nfp_fifo_s s_q;
	nfp_fifo_s s_d;
	logic push;
	logic pop;

	assign in_ready = s_q.count != (PW+1)'(DEPTH);
	assign out_valid = s_q.count != '0;
	assign out_data = s_q.mem[s_q.rd_ptr];

	always_comb begin
		s_d = s_q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (flush) begin
			s_d.wr_ptr = '0;
			s_d.rd_ptr = '0;
			s_d.count = '0;
		end else begin
			if (push) begin
				s_d.mem[s_q.wr_ptr] = in_data;
				s_d.wr_ptr = s_q.wr_ptr + 1'b1;
			end
			if (pop) begin
				s_d.rd_ptr = s_q.rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				s_d.count = s_q.count + 1'b1;
			end else if (pop && !push) begin
				s_d.count = s_q.count - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : nfp_fifo

// *** verilog/nfp_mem.sv ***
`timescale 1ns/1ns

module nfp_mem #(
	parameter int AW = 5,
	parameter int DW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read port, one cycle latency
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	typedef struct packed {
		logic [(2**AW)-1:0][DW-1:0] arr;
		logic [DW-1:0] rdata;
	} nfp_mem_s;

	nfp_mem_s s_q;
	nfp_mem_s s_d;

	assign rdata = s_q.rdata;

	always_comb begin
		s_d = s_q;
		s_d.rdata = s_q.arr[raddr];
		if (we) begin
			s_d.arr[waddr] = wdata;
		end
	end

	// erased array comes up all ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : nfp_mem

// *** verilog/nfp_pin_port.sv ***
// Summary of operation
// - wait pin polarity follows bit 10 of the read configuration register.
// - wait pin driven only with select and output enable both low.
// - synchronous bursts assert wait for invalid data, deassert when valid.
// - wait stays deasserted in asynchronous reads and during writes.
// - address is 24 bits for smaller density, 25 bits for larger.
// - top address bit high routes the access to the top die.
// - synchronous reads capture address at strobe rise or first clock edge.
// - high select deselects, enters standby, floats data and wait.
// - data drivers on only in reads with output enable low.
// - link clock times synchronous reads; unused it is held steady.
// - asynchronous mode latches address at strobe rise, flows while low.
// - writes latch address and data at first rise of write strobe or select.
// - reset clears automation, blocks writes, returns to asynchronous array read.
`timescale 1ns/1ns
`include "nfp_defines.svh"

module nfp_pin_port (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// address and strobes from the host
	input wire logic [`NFP_ADDR_W-1:0] ADDR_IN,
	input wire logic ADDRESS_VALID_STROBE_N,
	input wire logic DIE_SELECT_N,
	input wire logic DIE_OUTPUT_ENABLE_N,
	input wire logic WRITE_ENABLE_N,
	input wire logic LINK_CLK,
	// data pins
	input wire logic [`NFP_DQ_W-1:0] DQ_I,
	output logic [`NFP_DQ_W-1:0] DQ_O,
	output logic DQ_OE_N,
	// wait pin
	output logic WAIT_O,
	output logic WAIT_OE_N,
	// density strap
	input wire logic WIDE_DENSITY,
	// read configuration from command logic
	input wire logic CFG_LOAD,
	input wire logic [`NFP_CFG_W-1:0] CFG_DATA,
	output logic [`NFP_CFG_W-1:0] READ_CONFIG_REG,
	// die routing and power state
	output logic [1:0] DIE_ACTIVE,
	output logic STANDBY
);

	nfp_pkg::nfp_state_s s_q;
	nfp_pkg::nfp_state_s s_d;
	nfp_pkg::nfp_pins_s pins_in;
	nfp_pkg::nfp_pins_s p;
	nfp_pkg::nfp_pins_s q;

	logic sync_mode;
	logic wait_pol;
	logic adv_rise;
	logic clk_rise;
	logic start;
	logic reading;
	logic wr_fire;
	logic [`NFP_ADDR_W-1:0] a_in;

	logic mem_we;
	logic [`NFP_MEM_AW-1:0] mem_waddr;
	logic [`NFP_MEM_AW-1:0] mem_raddr;
	logic [`NFP_DQ_W-1:0] mem_rdata;

	logic fifo_flush;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [`NFP_DQ_W-1:0] fifo_out_data;

	function automatic logic rise(input logic prev, input logic now);
		rise = !prev && now;
	endfunction : rise

	// smaller density ignores the top address bit
	function automatic logic [`NFP_ADDR_W-1:0] mask_addr(input logic [`NFP_ADDR_W-1:0] a, input logic wide);
		mask_addr = a;
		mask_addr[`NFP_TOP_BIT] = a[`NFP_TOP_BIT] && wide;
	endfunction : mask_addr

	// top address bit picks the die, low bits the word
	function automatic logic [`NFP_MEM_AW-1:0] mem_idx(input logic [`NFP_ADDR_W-1:0] a);
		mem_idx = {a[`NFP_TOP_BIT], a[`NFP_MEM_LOW_BITS-1:0]};
	endfunction : mem_idx

	function automatic logic wait_level(input logic asrt, input logic pol);
		wait_level = pol ? asrt : !asrt;
	endfunction : wait_level

	always_comb begin
		pins_in.ce_n = DIE_SELECT_N;
		pins_in.oe_n = DIE_OUTPUT_ENABLE_N;
		pins_in.we_n = WRITE_ENABLE_N;
		pins_in.adv_n = ADDRESS_VALID_STROBE_N;
		pins_in.link_clk = LINK_CLK;
		pins_in.wide = WIDE_DENSITY;
		pins_in.a = ADDR_IN;
		pins_in.dq = DQ_I;
	end

	nfp_mem #(
		.AW(`NFP_MEM_AW),
		.DW(`NFP_DQ_W)
	) u_mem (
		.clk(CLK),
		.rst_n(RST_N),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(s_q.pin_prev.dq),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	nfp_fifo #(
		.W(`NFP_DQ_W),
		.DEPTH(`NFP_FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.flush(fifo_flush),
		.in_valid(s_q.rd_pend),
		.in_data(mem_rdata),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// write ends at first rise of write strobe or select
	assign wr_fire = !s_q.pin_prev.ce_n && !s_q.pin_prev.we_n
		&& (s_q.pin2.ce_n || s_q.pin2.we_n);
	assign mem_we = wr_fire;
	assign mem_waddr = mem_idx(s_q.addr);
	assign mem_raddr = (s_q.burst == nfp_pkg::NFP_IDLE) ? mem_idx(s_q.addr) : mem_idx(s_q.fill_addr);

	always_comb begin
		s_d = s_q;
		p = s_q.pin2;
		q = s_q.pin_prev;
		// two stage pin synchroniser
		s_d.pin1 = pins_in;
		s_d.pin2 = s_q.pin1;
		s_d.pin_prev = s_q.pin2;
		start = 1'b0;
		fifo_pop = 1'b0;

		// strap followed until the synchroniser holds the real pin, then frozen
		if (!s_q.strap_done) begin
			s_d.wide = p.wide;
			s_d.lat_cnt = s_q.lat_cnt + 3'h1;
			if (s_q.lat_cnt == 3'h2) begin
				s_d.strap_done = 1'b1;
				s_d.lat_cnt = 3'h0;
			end
		end
		if (CFG_LOAD) begin
			s_d.cfg = CFG_DATA;
		end

		sync_mode = !s_q.cfg[`NFP_CFG_ASYNC_BIT];
		wait_pol = s_q.cfg[`NFP_CFG_WAIT_POL_BIT];
		adv_rise = rise(q.adv_n, p.adv_n);
		clk_rise = rise(q.link_clk, p.link_clk);
		a_in = mask_addr(p.a, s_q.wide);

		// address latch
		if (!p.adv_n && !sync_mode) begin
			s_d.addr = a_in;
		end
		if (adv_rise) begin
			s_d.captured = 1'b0;
			if (!sync_mode || !s_q.captured) begin
				s_d.addr = mask_addr(q.a, s_q.wide);
				start = sync_mode;
			end
		end else if (sync_mode && !p.adv_n && clk_rise && !s_q.captured) begin
			s_d.addr = a_in;
			s_d.captured = 1'b1;
			start = 1'b1;
		end

		fifo_flush = start || p.ce_n;

		// prefetch, one read in flight
		s_d.rd_pend = 1'b0;
		if (s_q.burst != nfp_pkg::NFP_IDLE && !s_q.rd_pend && fifo_in_ready && !fifo_flush) begin
			s_d.rd_pend = 1'b1;
			s_d.fill_addr = s_q.fill_addr + 1'b1;
		end

		case (s_q.burst)
			nfp_pkg::NFP_IDLE: begin
				s_d.wait_asrt = 1'b0;
				s_d.dq_o = mem_rdata;
			end
			nfp_pkg::NFP_FILL: begin
				s_d.wait_asrt = 1'b1;
				if (clk_rise) begin
					s_d.lat_cnt = s_q.lat_cnt + 1'b1;
					if (s_q.lat_cnt == `NFP_LATENCY_EDGES - 3'h1) begin
						s_d.burst = nfp_pkg::NFP_BURST;
					end
				end
			end
			nfp_pkg::NFP_BURST: begin
				if (clk_rise) begin
					if (fifo_out_valid) begin
						fifo_pop = 1'b1;
						s_d.dq_o = fifo_out_data;
						s_d.wait_asrt = 1'b0;
					end else begin
						s_d.wait_asrt = 1'b1;
					end
				end
			end
			default: begin
				s_d.burst = nfp_pkg::NFP_IDLE;
			end
		endcase

		if (start) begin
			s_d.burst = nfp_pkg::NFP_FILL;
			s_d.lat_cnt = 3'h0;
			s_d.fill_addr = s_d.addr;
			s_d.wait_asrt = 1'b1;
		end
		if (p.ce_n || !sync_mode) begin
			s_d.burst = nfp_pkg::NFP_IDLE;
		end
		if (!p.we_n) begin
			s_d.wait_asrt = 1'b0;
		end

		// pin drivers
		reading = !p.ce_n && !p.oe_n && p.we_n;
		s_d.dq_oe_n = !reading;
		s_d.wait_oe_n = p.ce_n || p.oe_n;
		s_d.wait_o = wait_level(s_d.wait_asrt, wait_pol);

		// die routing and standby
		s_d.standby = p.ce_n;
		if (p.ce_n) begin
			s_d.die_act = 2'h0;
		end else if (s_d.addr[`NFP_TOP_BIT]) begin
			s_d.die_act = 2'h2;
		end else begin
			s_d.die_act = 2'h1;
		end
	end

	// reset clears state but sets synchronised pins, standby and driver disables high, leaves asynchronous array read
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.pin1 <= '1;
			s_q.pin2 <= '1;
			s_q.pin_prev <= '1;
			s_q.cfg <= `NFP_CFG_RESET;
			s_q.burst <= nfp_pkg::NFP_IDLE;
			s_q.dq_oe_n <= 1'b1;
			s_q.wait_oe_n <= 1'b1;
			s_q.wait_o <= 1'b0;
			s_q.standby <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign DQ_O = s_q.dq_o;
	assign DQ_OE_N = s_q.dq_oe_n;
	assign WAIT_O = s_q.wait_o;
	assign WAIT_OE_N = s_q.wait_oe_n;
	assign READ_CONFIG_REG = s_q.cfg;
	assign DIE_ACTIVE = s_q.die_act;
	assign STANDBY = s_q.standby;

endmodule : nfp_pin_port

// *** sim/nfp_pin_port_assertions.sv ***
`timescale 1ns/1ns
`include "nfp_defines.svh"
module nfp_pin_port_checker (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// host pins
	input wire logic DIE_SELECT_N,
	input wire logic DIE_OUTPUT_ENABLE_N,
	input wire logic WRITE_ENABLE_N,
	input wire logic WIDE_DENSITY,
	input wire logic CFG_LOAD,
	input wire logic [`NFP_CFG_W-1:0] CFG_DATA,
	// device outputs
	input wire logic [`NFP_DQ_W-1:0] DQ_O,
	input wire logic DQ_OE_N,
	input wire logic WAIT_O,
	input wire logic WAIT_OE_N,
	input wire logic [`NFP_CFG_W-1:0] READ_CONFIG_REG,
	input wire logic [1:0] DIE_ACTIVE,
	input wire logic STANDBY
);
	logic ok_lvl;
	logic sync_q;
	// wait level meaning valid data
	assign ok_lvl = ~READ_CONFIG_REG[`NFP_CFG_WAIT_POL_BIT];
	assign sync_q = ~READ_CONFIG_REG[`NFP_CFG_ASYNC_BIT];
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	a_desel_float: assert property (DIE_SELECT_N [*4] |-> WAIT_OE_N && DQ_OE_N)
		else $error("driving while deselected");
	a_oe_float: assert property (DIE_OUTPUT_ENABLE_N [*4] |-> WAIT_OE_N && DQ_OE_N)
		else $error("driving with output enable high");
	a_read_drive: assert property ((!DIE_SELECT_N && !DIE_OUTPUT_ENABLE_N && WRITE_ENABLE_N) [*4]
		|-> !WAIT_OE_N && !DQ_OE_N) else $error("read not driven");
	a_standby_off: assert property (DIE_SELECT_N [*4] |-> STANDBY && DIE_ACTIVE == 2'h0)
		else $error("no standby when deselected");
	a_select_on: assert property (!DIE_SELECT_N [*4] |-> !STANDBY)
		else $error("standby while selected");
	a_async_idle: assert property (!sync_q && $stable(READ_CONFIG_REG) && !WAIT_OE_N |-> WAIT_O == ok_lvl)
		else $error("wait asserted outside burst");
	a_cfg_load: assert property (CFG_LOAD |=> READ_CONFIG_REG == $past(CFG_DATA))
		else $error("config not loaded");
	a_burst_data: assert property (sync_q && $stable(READ_CONFIG_REG) && !DQ_OE_N && $changed(DQ_O)
		|-> WAIT_O == ok_lvl) else $error("new word without valid wait");
	a_narrow_die: assert property (!WIDE_DENSITY && $stable(WIDE_DENSITY) |-> !DIE_ACTIVE[1])
		else $error("top die in narrow density");
	c_burst_word: cover property (sync_q && !DQ_OE_N && $changed(DQ_O));
	c_top_die: cover property (DIE_ACTIVE == 2'h2);
	c_cfg_load: cover property (CFG_LOAD);
endmodule : nfp_pin_port_checker

bind nfp_pin_port nfp_pin_port_checker u_chk (.CLK, .RST_N, .DIE_SELECT_N, .DIE_OUTPUT_ENABLE_N,
	.WRITE_ENABLE_N, .WIDE_DENSITY, .CFG_LOAD, .CFG_DATA, .DQ_O, .DQ_OE_N, .WAIT_O, .WAIT_OE_N,
	.READ_CONFIG_REG, .DIE_ACTIVE, .STANDBY);

// *** sim/nfp_host_model.sv ***
`timescale 1ns/1ns
`include "nfp_defines.svh"
module nfp_host_model (
	// device clock
	input wire logic clk,
	// host driven pins
	output logic [`NFP_ADDR_W-1:0] a,
	output logic adv_n,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic lclk,
	output logic [`NFP_DQ_W-1:0] dq,
	// device pins seen
	input wire logic [`NFP_DQ_W-1:0] q,
	input wire logic wt,
	input wire logic pol
);
	logic [`NFP_DQ_W-1:0] got [$];
	initial begin
		a = '0;
		adv_n = 1'b1;
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		lclk = 1'b0;
		dq = '0;
	end
	// pins held seven cycles
	task automatic set(input logic c, o, w, v);
		@(posedge clk);
		ce_n <= c;
		oe_n <= o;
		we_n <= w;
		adv_n <= v;
		repeat (7) @(negedge clk);
	endtask : set
	// word address, bit 0 least significant
	task automatic wr(input logic [`NFP_ADDR_W-1:0] ad, input logic [`NFP_DQ_W-1:0] d);
		@(posedge clk);
		a <= ad;
		dq <= d;
		set(1'b0, 1'b1, 1'b0, 1'b0);
		set(1'b0, 1'b1, 1'b1, 1'b0);
		@(posedge clk);
		dq <= ~d;
		set(1'b1, 1'b1, 1'b1, 1'b1);
	endtask : wr
	task automatic rd(input logic [`NFP_ADDR_W-1:0] ad);
		@(posedge clk);
		a <= ad;
		set(1'b0, 1'b0, 1'b1, 1'b0);
	endtask : rd
	// link clock runs only inside the burst
	task automatic burst(input logic [`NFP_ADDR_W-1:0] ad, input int n);
		got.delete();
		rd(ad);
		for (int i = 0; i < 12 && got.size() < n; i++) begin
			@(posedge clk);
			lclk <= 1'b1;
			repeat (4) @(posedge clk);
			lclk <= 1'b0;
			repeat (4) @(negedge clk);
			if (wt != pol) begin
				got.push_back(q);
			end
		end
	endtask : burst
endmodule : nfp_host_model

// *** sim/nfp_pin_port_tb_top.sv ***
`timescale 1ns/1ns
`include "nfp_defines.svh"
module nfp_pin_port_tb_top;
	typedef struct packed {
		logic [`NFP_ADDR_W-1:0] a;
		logic [`NFP_DQ_W-1:0] d;
		logic [1:0] die;
	} nfp_row_s;
	localparam nfp_row_s ROWS [4] = '{'{25'h0000003, 16'hA5C3, 2'h1}, '{25'h0000004, 16'h5A3C, 2'h1},
		'{25'h1000003, 16'h0F0F, 2'h2}, '{25'h100000F, 16'h1234, 2'h2}};
	logic clk, rst_n, wide, cfg_load, adv_n, ce_n, oe_n, we_n, lclk, dq_oe_n, wait_o, wait_oe_n, stby;
	logic [`NFP_CFG_W-1:0] cfg_data, cfg;
	logic [`NFP_ADDR_W-1:0] a;
	logic [`NFP_DQ_W-1:0] dq_i, dq_o;
	logic [1:0] die;
	int errors;
	int n_compared;
	nfp_host_model u_host (.clk(clk), .a(a), .adv_n(adv_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.lclk(lclk), .dq(dq_i), .q(dq_o), .wt(wait_o), .pol(cfg[`NFP_CFG_WAIT_POL_BIT]));
	nfp_pin_port DUT (.CLK(clk), .RST_N(rst_n), .ADDR_IN(a), .ADDRESS_VALID_STROBE_N(adv_n),
		.DIE_SELECT_N(ce_n), .DIE_OUTPUT_ENABLE_N(oe_n), .WRITE_ENABLE_N(we_n), .LINK_CLK(lclk),
		.DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .WAIT_O(wait_o), .WAIT_OE_N(wait_oe_n),
		.WIDE_DENSITY(wide), .CFG_LOAD(cfg_load), .CFG_DATA(cfg_data), .READ_CONFIG_REG(cfg),
		.DIE_ACTIVE(die), .STANDBY(stby));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task automatic load(input logic [`NFP_CFG_W-1:0] v);
		@(posedge clk);
		cfg_load <= 1'b1;
		cfg_data <= v;
		@(posedge clk);
		cfg_load <= 1'b0;
	endtask : load
	task automatic idle_chk();
		u_host.set(1'b1, 1'b1, 1'b1, 1'b1);
		chk("standby", {stby, die}, 3'h4);
		chk("floats", {wait_oe_n, dq_oe_n}, 2'h3);
	endtask : idle_chk
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#300000;
		errors++;
		summarize();
	end
	initial begin
		errors = 0;
		n_compared = 0;
		rst_n = 1'b0;
		wide = 1'b1;
		cfg_load = 1'b0;
		cfg_data = '0;
		repeat (11) @(posedge clk);
		chk("cfg reset", cfg, `NFP_CFG_RESET);
		chk("pins reset", {dq_o, dq_oe_n, wait_oe_n, stby, die}, {16'h0000, 3'h7, 2'h0});
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (ROWS[i]) u_host.wr(ROWS[i].a, ROWS[i].d);
		foreach (ROWS[i]) begin
			u_host.rd(ROWS[i].a);
			chk("read data", dq_o, ROWS[i].d);
			chk("die", die, ROWS[i].die);
			chk("drive", {dq_oe_n, wait_oe_n, wait_o}, 3'h0);
			idle_chk();
		end
		load(16'h8000);
		u_host.rd(ROWS[1].a);
		chk("low polarity", {wait_oe_n, wait_o}, 2'h1);
		idle_chk();
		load(16'h0400);
		u_host.burst(ROWS[0].a, 3);
		chk("burst count", u_host.got.size(), 3);
		for (int i = 0; i < u_host.got.size(); i++) begin
			chk("burst word", u_host.got[i], i < 2 ? ROWS[i].d : `NFP_MEM_ERASED);
		end
		idle_chk();
		u_host.burst(ROWS[2].a, 1);
		chk("top burst", u_host.got[0], ROWS[2].d);
		idle_chk();
		@(posedge clk);
		rst_n <= 1'b0;
		wide <= 1'b0;
		u_host.wr(25'h0000005, 16'h0000);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		u_host.rd(25'h1000005);
		chk("narrow die", die, 2'h1);
		chk("write blocked", dq_o, `NFP_MEM_ERASED);
		idle_chk();
		summarize();
	end
endmodule : nfp_pin_port_tb_top
